// ---- hdl/pma_top.sv ----
// programmable macrocell array: routing, product terms, expanders, pin control
`timescale 1ns/10ps
`default_nettype none
module pma_top (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [pma_pkg::AW-1:0] reg_addr,
	input wire logic [pma_pkg::DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pma_pkg::DW-1:0] reg_rdata,
	input wire logic global_clock_pin_a,
	input wire logic global_clear_pin_low,
	input wire logic output_enable_pin_a_low,
	input wire logic output_enable_pin_b_low,
	input wire logic [pma_pkg::N_IO-1:0] io_in,
	output logic [pma_pkg::N_IO-1:0] io_out,
	output logic [pma_pkg::N_IO-1:0] io_oe
);
	import pma_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	// one product term: and of chosen true and complement literals
	function automatic logic pterm(
		input logic [N_LIT-1:0] lit,
		input logic [N_LIT-1:0] tm,
		input logic [N_LIT-1:0] cm
	);
		pterm = ((tm | cm) != '0) && (&(lit | ~tm)) && (&(~lit | ~cm));
	endfunction

	// sets borrowed from lower neighbours in the same chain
	function automatic logic borrowed_sum(
		input logic [N_MC-1:0] sets,
		input logic [N_MC-1:0] lends,
		input int mc,
		input logic [1:0] count
	);
		int pos;
		pos = mc % CHAIN_LEN;
		borrowed_sum = 1'b0;
		for (int k = 1; k <= SETS_LIMIT; k++)
		begin
			if ((k <= int'(count)) && (k <= pos) && lends[mc-k])
				borrowed_sum = borrowed_sum | sets[mc-k];
		end
	endfunction

	// ------------------------------------------------------------
	// configuration store
	// ------------------------------------------------------------

	pma_cfg_if cfg_bus ();
	logic [DW-1:0] cw [CFG_DEPTH];
	logic [DW-1:0] glb;
	logic enh;

	pma_cfg_store u_store (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.cfg_bus(cfg_bus)
	);

	// register port straight into the store
	assign cfg_bus.wr = reg_wr;
	assign cfg_bus.rd = reg_rd;
	assign cfg_bus.addr = reg_addr;
	assign cfg_bus.wdata = reg_wdata;
	assign reg_rdata = cfg_bus.rdata;

	// unpacked view of the stored words
	genvar gw;
	for (gw = 0; gw < CFG_DEPTH; gw++)
	begin : g_words
		assign cw[gw] = cfg_bus.cfg[gw*DW +: DW];
	end
	assign glb = cw[GLB_ADDR];
	assign enh = glb[G_ENH];

	// ------------------------------------------------------------
	// pin synchronisers and global clock edges
	// ------------------------------------------------------------

	logic [N_DED-1:0] ded_s1_r;
	logic [N_DED-1:0] ded_s2_r;
	logic [N_IO-1:0] io_s1_r;
	logic [N_IO-1:0] io_s2_r;
	logic [N_GCLK-1:0] gclk_prev_r;
	logic [N_DED-1:0] ded_s1_nxt;
	logic [N_DED-1:0] ded_s2_nxt;
	logic [N_IO-1:0] io_s1_nxt;
	logic [N_IO-1:0] io_s2_nxt;
	logic [N_GCLK-1:0] gclk_prev_nxt;
	logic [N_GCLK-1:0] gclk_lvl;
	logic [N_GCLK-1:0] gclk_rise;
	logic pin_b_clk;

	// two stages for every pin before any use
	always_comb
	begin
		ded_s1_nxt = {output_enable_pin_b_low, output_enable_pin_a_low,
			global_clear_pin_low, global_clock_pin_a};
		ded_s2_nxt = ded_s1_r;
		io_s1_nxt = io_in;
		io_s2_nxt = io_s1_r;
		gclk_prev_nxt = gclk_lvl;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			ded_s1_r <= '0;
			ded_s2_r <= '0;
			io_s1_r <= '0;
			io_s2_r <= '0;
			gclk_prev_r <= '0;
		end
		else
		begin
			ded_s1_r <= ded_s1_nxt;
			ded_s2_r <= ded_s2_nxt;
			io_s1_r <= io_s1_nxt;
			io_s2_r <= io_s2_nxt;
			gclk_prev_r <= gclk_prev_nxt;
		end
	end

	// pin b doubles as the second clock pin in enhanced mode
	assign pin_b_clk = ded_s2_r[DED_OE_B];

	// global clock sources, true or complement in enhanced mode
	genvar gc;
	for (gc = 0; gc < N_GCLK; gc++)
	begin : g_gclk
		logic sel;
		logic inv;
		assign sel = glb[G_CLK_SRC + 2*gc];
		assign inv = glb[G_CLK_SRC + 2*gc + 1];
		if (gc == 0)
		begin : g_first
			assign gclk_lvl[gc] = enh ? ((sel ? pin_b_clk : ded_s2_r[DED_CLK_A]) ^ inv)
				: ded_s2_r[DED_CLK_A];
		end
		else
		begin : g_other
			assign gclk_lvl[gc] = enh & ((sel ? pin_b_clk : ded_s2_r[DED_CLK_A]) ^ inv);
		end
	end
	assign gclk_rise = gclk_lvl & ~gclk_prev_r;

	// ------------------------------------------------------------
	// global output enables
	// ------------------------------------------------------------

	logic [N_GOE-1:0] goe;
	logic en_a;
	logic en_b;
	logic [N_MC-1:0] mc_q;

	assign en_a = ~ded_s2_r[DED_OE_A];
	assign en_b = ~ded_s2_r[DED_OE_B];

	genvar ge;
	for (ge = 0; ge < N_GOE; ge++)
	begin : g_goe
		pma_oe_src_t src;
		logic enh_val;
		logic small_val;
		assign src = pma_oe_src_t'(glb[G_OE_SRC + 3*ge +: 3]);
		// six enables from pins, their complements, io pins or macrocells
		always_comb
		begin
			case (src)
				OS_A_TRUE: enh_val = en_a;
				OS_A_COMP: enh_val = ~en_a;
				OS_B_TRUE: enh_val = en_b;
				OS_B_COMP: enh_val = ~en_b;
				OS_PIN: enh_val = io_s2_r[ge];
				OS_MC: enh_val = mc_q[ge];
				default: enh_val = 1'b0;
			endcase
		end
		// small mode uses the two active-low enable pins
		assign small_val = (ge == 0) ? en_a : ((ge == 1) ? en_b : 1'b0);
		assign goe[ge] = enh ? enh_val : small_val;
	end

	// ------------------------------------------------------------
	// global routing array and block input lines
	// ------------------------------------------------------------

	logic [N_ROUTE-1:0] route;
	logic [LAB_LINES-1:0] line_v [N_LAB];
	logic [MC_PER_LAB-1:0] shexp [N_LAB];

	// dedicated inputs, pins and macrocell outputs all feed the array
	assign route = {mc_q, io_s2_r, ded_s2_r};

	// each block picks its own lines from the array
	genvar gl;
	genvar gk;
	for (gl = 0; gl < N_LAB; gl++)
	begin : g_lab
		for (gk = 0; gk < LAB_LINES; gk++)
		begin : g_line
			logic [LINE_FLD-1:0] fld;
			logic [SEL_W-1:0] idx;
			logic src_bit;
			assign fld = cw[ROUTE_BASE + gl*ROUTE_STRIDE + gk/LINES_PER_WORD]
				[(gk % LINES_PER_WORD)*LINE_FLD +: LINE_FLD];
			assign idx = fld[SEL_W-1:0];
			assign src_bit = (idx < SEL_W'(N_ROUTE)) ? route[idx] : 1'b0;
			// enable bit gates one input of a 2-input AND
			assign line_v[gl][gk] = fld[SEL_W] & src_bit;
		end
	end

	// ------------------------------------------------------------
	// macrocells with product terms and expanders
	// ------------------------------------------------------------

	logic [N_MC-1:0] set_v;
	logic [N_MC-1:0] lend_v;
	logic [N_IO-1:0] oe_v;

	genvar gm;
	genvar gt;
	for (gm = 0; gm < N_MC; gm++)
	begin : g_mc
		localparam int LOGIC_ARRAY_BLOCK = gm / MC_PER_LAB;
		localparam int SLOT = gm % MC_PER_LAB;
		localparam int POS = gm % CHAIN_LEN;
		localparam int BASE = gm * MC_STRIDE;
		logic [DW-1:0] ctrl;
		logic [N_LIT-1:0] lit;
		logic [N_LIT-1:0] lit_noexp;
		logic [N_TERMS-1:0] term;
		logic [N_TERMS-1:0] divert;
		logic [1:0] borrow_cnt;
		logic sum;
		logic xor_out;
		logic d_in;
		pma_ff_t ff_type;
		pma_clk_t clk_mode;
		pma_oe_t oe_mode;
		logic [2:0] oe_idx;

		assign ctrl = cw[BASE + CTRL_WORD];
		assign ff_type = pma_ff_t'(ctrl[F_FF_TYPE +: 2]);
		assign clk_mode = pma_clk_t'(ctrl[F_CLK_MODE +: 2]);
		assign lit = {shexp[LOGIC_ARRAY_BLOCK], line_v[LOGIC_ARRAY_BLOCK]};
		assign lit_noexp = {{MC_PER_LAB{1'b0}}, line_v[LOGIC_ARRAY_BLOCK]};

		for (gt = 0; gt < N_TERMS; gt++)
		begin : g_term
			logic [2*DW-1:0] tm;
			logic [2*DW-1:0] cm;
			assign tm = {cw[BASE + gt*WORDS_PER_TERM + 1], cw[BASE + gt*WORDS_PER_TERM]};
			assign cm = {cw[BASE + gt*WORDS_PER_TERM + 3], cw[BASE + gt*WORDS_PER_TERM + 2]};
			// the shared term never sees expanders, so no loop can form
			assign term[gt] = pterm((gt == T_SHARE) ? lit_noexp : lit,
				tm[N_LIT-1:0], cm[N_LIT-1:0]);
		end

		// select matrix steers terms away from the OR gate
		assign divert[T_SECOND] = ctrl[F_SECOND] & ((ff_type == FF_JK) | (ff_type == FF_SR));
		assign divert[T_CTRL] = ctrl[F_REGD] & (clk_mode != CK_GLOBAL);
		assign divert[T_CLR] = ctrl[F_CLR_TERM];
		assign divert[T_PRE] = ctrl[F_PRE_TERM];
		assign divert[T_SHARE] = ctrl[F_SHARE];

		// inverted shared term fed back into its block
		assign shexp[LOGIC_ARRAY_BLOCK][SLOT] = ctrl[F_SHARE] & ~term[T_SHARE];

		// highest of a chain never lends, lowest never borrows
		assign set_v[gm] = |(term & ~divert);
		assign lend_v[gm] = ctrl[F_LEND] & (POS != CHAIN_LEN - 1);
		assign borrow_cnt = (POS == 0) ? 2'h0 : ctrl[F_BORROW +: 2];

		// own terms plus up to three borrowed sets
		// chain position keeps borrowing inside eight macrocells
		assign sum = (lend_v[gm] ? 1'b0 : set_v[gm])
			| borrowed_sum(set_v, lend_v, gm, borrow_cnt);
		assign xor_out = sum ^ ctrl[F_XOR_POL];

		// fast pin path into the register in enhanced mode
		assign d_in = (enh & ctrl[F_FAST_IN] & ctrl[F_REGD]) ? io_s2_r[gm] : xor_out;

		pma_macrocell u_mc (
			.sys_clk(sys_clk),
			.rst_n(rst_n),
			.ff_type(ff_type),
			.regd(ctrl[F_REGD]),
			.clk_mode(clk_mode),
			.d_in(d_in),
			.second_in(divert[T_SECOND] & term[T_SECOND]),
			// second global clock only in enhanced mode
			.gclk_edge(gclk_rise[enh & ctrl[F_GCLK_SEL]]),
			.ctrl_term(term[T_CTRL]),
			// global clear pin, active low, per register
			.clr((divert[T_CLR] & term[T_CLR]) | (ctrl[F_GCLR_EN] & ~ded_s2_r[DED_CLR])),
			.pre(divert[T_PRE] & term[T_PRE]),
			.q(mc_q[gm])
		);

		// tri-state control from a global enable or tied
		// tied low leaves the pin as input, tied high drives
		assign oe_mode = pma_oe_t'(ctrl[F_OE_MODE +: 2]);
		assign oe_idx = ctrl[F_OE_IDX +: 3];
		// off and unknown modes leave the pin undriven
		assign oe_v[gm] = (oe_mode == OE_ON)
			| ((oe_mode == OE_GLOBAL) & (oe_idx < 3'(N_GOE)) & goe[oe_idx]);
	end

	// ------------------------------------------------------------
	// pin output registers and status
	// ------------------------------------------------------------

	logic [N_IO-1:0] io_out_r;
	logic [N_IO-1:0] io_oe_r;
	logic [N_IO-1:0] io_out_nxt;
	logic [N_IO-1:0] io_oe_nxt;

	// pin drivers follow macrocell outputs and enables
	always_comb
	begin
		io_out_nxt = mc_q;
		io_oe_nxt = oe_v;
	end

	// pins undriven and low after power-up
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			io_out_r <= '0;
			io_oe_r <= '0;
		end
		else
		begin
			io_out_r <= io_out_nxt;
			io_oe_r <= io_oe_nxt;
		end
	end

	assign io_out = io_out_r;
	assign io_oe = io_oe_r;

	// status words readable over the register port
	assign cfg_bus.stat_mc = mc_q;
	assign cfg_bus.stat_io = io_s2_r;
	assign cfg_bus.stat_ded = {{(DW-N_DED){1'b0}}, ded_s2_r};
endmodule
`default_nettype wire

// ---- include/pma_pkg.sv ----
// constants, field layouts and types of the programmable macrocell array
// Summary of operation
// - four dedicated inputs act as general inputs or global clock, clear, enables.
// - macrocells form blocks of sixteen, joined by a global routing array.
// - routing array carries all sources; a bit-gated 2-input AND picks lines.
// - five product terms per macrocell feed OR/XOR or register controls.
// - each flip-flop works as a D, T, JK or SR type.
// - each macrocell output is combinational or registered.
// - clocking by global clock, global clock with enable, or array clock.
// - enhanced mode has two selectable global clocks; otherwise pin a only.
// - active-high product-term preset and clear act asynchronously.
// - the active-low global clear pin may clear each register.
// - every register starts at zero after power-up.
// - enhanced mode offers a fast path from pin to register D.
// - sixteen shareable expanders per block, inverted terms usable by all.
// - parallel expanders add up to three sets of five terms.
// - lending stays within two chains of eight macrocells per block.
// - borrow from lower neighbours only; lowest only lends, highest only borrows.
// - each pin is input, output or two-way; enable global, off or on.
// - small mode takes two global enables from active-low enable pins.
// - enhanced mode has six global enables from enable pins, pins or macrocells.
// - enable tied low makes the pin input only; tied high keeps it driving.
package pma_pkg;
	// ------------------------------------------------------------
	// array geometry
	// ------------------------------------------------------------
	localparam int N_LAB = 2;
	localparam int MC_PER_LAB = 16;
	localparam int N_MC = N_LAB * MC_PER_LAB;
	localparam int N_DED = 4;
	localparam int N_IO = N_MC;
	localparam int N_ROUTE = N_DED + N_IO + N_MC;
	localparam int LAB_LINES = 36;
	localparam int N_TERMS = 5;
	localparam int N_LIT = LAB_LINES + MC_PER_LAB;
	localparam int CHAIN_LEN = 8;
	localparam int SETS_LIMIT = 3;
	localparam int N_GOE = 6;
	localparam int N_GCLK = 2;
	// dedicated input positions
	localparam int DED_CLK_A = 0;
	localparam int DED_CLR = 1;
	localparam int DED_OE_A = 2;
	localparam int DED_OE_B = 3;
	// ------------------------------------------------------------
	// register port and word map
	// ------------------------------------------------------------
	localparam int DW = 32;
	localparam int AW = 11;
	localparam int MC_STRIDE = 32;
	localparam int WORDS_PER_TERM = 4;
	localparam int CTRL_WORD = 20;
	localparam int ROUTE_BASE = 1024;
	localparam int ROUTE_STRIDE = 16;
	localparam int LINES_PER_WORD = 4;
	localparam int LINE_FLD = 8;
	localparam int SEL_W = 7;
	localparam int GLB_ADDR = 1056;
	localparam logic [AW-1:0] STAT_MC_ADDR = 11'h421;
	localparam logic [AW-1:0] STAT_IO_ADDR = 11'h422;
	localparam logic [AW-1:0] STAT_DED_ADDR = 11'h423;
	localparam int CFG_DEPTH = GLB_ADDR + 1;
	localparam int CFG_BITS = CFG_DEPTH * DW;
	localparam logic [DW-1:0] CFG_RESET = 32'h0000_0000;
	// macrocell control word fields
	localparam int F_FF_TYPE = 0;
	localparam int F_REGD = 2;
	localparam int F_CLK_MODE = 3;
	localparam int F_GCLK_SEL = 5;
	localparam int F_GCLR_EN = 6;
	localparam int F_FAST_IN = 7;
	localparam int F_XOR_POL = 8;
	localparam int F_BORROW = 9;
	localparam int F_LEND = 11;
	localparam int F_OE_MODE = 12;
	localparam int F_OE_IDX = 14;
	localparam int F_CLR_TERM = 17;
	localparam int F_PRE_TERM = 18;
	localparam int F_SHARE = 19;
	localparam int F_SECOND = 20;
	// global word fields
	localparam int G_ENH = 0;
	localparam int G_CLK_SRC = 1;
	localparam int G_OE_SRC = 5;
	// product term roles when diverted
	localparam int T_SECOND = 0;
	localparam int T_CTRL = 1;
	localparam int T_CLR = 2;
	localparam int T_PRE = 3;
	localparam int T_SHARE = 4;
	typedef enum logic [1:0] {FF_D = 2'h0, FF_T = 2'h1, FF_JK = 2'h2, FF_SR = 2'h3} pma_ff_t;
	typedef enum logic [1:0] {CK_GLOBAL = 2'h0, CK_GLOBAL_EN = 2'h1, CK_ARRAY = 2'h2} pma_clk_t;
	typedef enum logic [1:0] {OE_OFF = 2'h0, OE_ON = 2'h1, OE_GLOBAL = 2'h2} pma_oe_t;
	typedef enum logic [2:0] {OS_A_TRUE = 3'h0, OS_A_COMP = 3'h1, OS_B_TRUE = 3'h2,
		OS_B_COMP = 3'h3, OS_PIN = 3'h4, OS_MC = 3'h5} pma_oe_src_t;
endpackage

// ---- include/pma_cfg_if.sv ----
// configuration store bundle between the array top and its store
`timescale 1ns/10ps
`default_nettype none
interface pma_cfg_if;
	import pma_pkg::*;
	logic wr;
	logic rd;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	logic [CFG_BITS-1:0] cfg;
	logic [DW-1:0] stat_mc;
	logic [DW-1:0] stat_io;
	logic [DW-1:0] stat_ded;
	modport store (input wr, rd, addr, wdata, stat_mc, stat_io, stat_ded, output rdata, cfg);
	modport ctrl (output wr, rd, addr, wdata, stat_mc, stat_io, stat_ded, input rdata, cfg);
endinterface
`default_nettype wire

// ---- hdl/pma_cfg_store.sv ----
// configuration word store with registered read port
`timescale 1ns/10ps
`default_nettype none
module pma_cfg_store (
	input wire logic sys_clk,
	input wire logic rst_n,
	pma_cfg_if.store cfg_bus
);
	import pma_pkg::*;
	logic [DW-1:0] mem_r [CFG_DEPTH];
	logic [DW-1:0] mem_nxt [CFG_DEPTH];
	logic [DW-1:0] rdata_r;
	logic [DW-1:0] rdata_nxt;
	// words change only on a bus write
	always_comb
	begin
		for (int i = 0; i < CFG_DEPTH; i++)
			mem_nxt[i] = mem_r[i];
		if (cfg_bus.wr && (cfg_bus.addr < AW'(CFG_DEPTH)))
			mem_nxt[cfg_bus.addr] = cfg_bus.wdata;
		rdata_nxt = '0;
		if (cfg_bus.rd)
		begin
			if (cfg_bus.addr < AW'(CFG_DEPTH))
				rdata_nxt = mem_r[cfg_bus.addr];
			else if (cfg_bus.addr == STAT_MC_ADDR)
				rdata_nxt = cfg_bus.stat_mc;
			else if (cfg_bus.addr == STAT_IO_ADDR)
				rdata_nxt = cfg_bus.stat_io;
			else if (cfg_bus.addr == STAT_DED_ADDR)
				rdata_nxt = cfg_bus.stat_ded;
		end
	end
	// word registers, cleared at reset
	always_ff @(posedge sys_clk)
	begin
		for (int i = 0; i < CFG_DEPTH; i++)
			mem_r[i] <= rst_n ? mem_nxt[i] : CFG_RESET;
		rdata_r <= rst_n ? rdata_nxt : CFG_RESET;
	end
	// flat view of every word for the array
	genvar g;
	for (g = 0; g < CFG_DEPTH; g++)
	begin : g_flat
		assign cfg_bus.cfg[g*DW +: DW] = mem_r[g];
	end
	assign cfg_bus.rdata = rdata_r;
endmodule
`default_nettype wire

// ---- hdl/pma_macrocell.sv ----
// configurable macrocell register with clock modes and async controls
`timescale 1ns/10ps
`default_nettype none
module pma_macrocell (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire pma_pkg::pma_ff_t ff_type,
	input wire logic regd,
	input wire pma_pkg::pma_clk_t clk_mode,
	input wire logic d_in,
	input wire logic second_in,
	input wire logic gclk_edge,
	input wire logic ctrl_term,
	input wire logic clr,
	input wire logic pre,
	output logic q
);
	import pma_pkg::*;
	logic val_r;
	logic val_nxt;
	logic aclk_prev_r;
	logic tick;
	logic ff_nxt;
	// clock event, flip-flop function and bypass
	always_comb
	begin
		case (clk_mode)
			CK_GLOBAL: tick = gclk_edge;
			CK_GLOBAL_EN: tick = gclk_edge & ctrl_term;
			CK_ARRAY: tick = ctrl_term & ~aclk_prev_r;
			default: tick = 1'b0;
		endcase
		case (ff_type)
			FF_D: ff_nxt = d_in;
			FF_T: ff_nxt = val_r ^ d_in;
			FF_JK: ff_nxt = (d_in & ~val_r) | (~second_in & val_r);
			FF_SR: ff_nxt = second_in ? 1'b0 : (d_in ? 1'b1 : val_r);
			default: ff_nxt = val_r;
		endcase
		if (!regd)
			val_nxt = d_in;
		// clear beats preset, both ignore the clock
		else if (clr)
			val_nxt = 1'b0;
		else if (pre)
			val_nxt = 1'b1;
		else if (tick)
			val_nxt = ff_nxt;
		else
			val_nxt = val_r;
	end
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			val_r <= 1'b0;
			aclk_prev_r <= 1'b0;
		end
		else
		begin
			val_r <= val_nxt;
			aclk_prev_r <= ctrl_term;
		end
	end
	assign q = val_r;
endmodule
`default_nettype wire

// ---- bench/pma_top_sva.sv ----
// assertion checker bound to the macrocell array top ports
`timescale 1ns/10ps
`default_nettype none
module pma_top_sva (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [pma_pkg::AW-1:0] reg_addr,
	input wire logic [pma_pkg::DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [pma_pkg::DW-1:0] reg_rdata,
	input wire logic global_clock_pin_a,
	input wire logic global_clear_pin_low,
	input wire logic output_enable_pin_a_low,
	input wire logic [pma_pkg::N_IO-1:0] io_out,
	input wire logic [pma_pkg::N_IO-1:0] io_oe
);
	import pma_pkg::*;
	logic [DW-1:0] ctl0_r;
	wire logic [2:0] ded_w = {output_enable_pin_a_low, global_clear_pin_low, global_clock_pin_a};
	// shadow of the macrocell 0 control word
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			ctl0_r <= 32'h0;
		else if (reg_wr && reg_addr == 11'h014)
			ctl0_r <= reg_wdata;
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// register port
	// ------------------------------------------------------------
	// idle data zero
	property p_rd_idle;
		!reg_rd |=> reg_rdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_unmapped;
		reg_rd && reg_addr > 11'h423 |=> reg_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_readback;
		reg_rd && reg_addr == 11'h014 |=> reg_rdata == $past(ctl0_r);
	endproperty
	a_readback: assert property (p_readback) else $error("control readback wrong");
	property p_ded;
		($stable(ded_w))[*4] ##0 (reg_rd && reg_addr == 11'h423)
			|=> reg_rdata[2:0] == $past(ded_w);
	endproperty
	a_ded: assert property (p_ded) else $error("dedicated status wrong");
	// ------------------------------------------------------------
	// pins and register
	// ------------------------------------------------------------
	// enable tied high
	property p_oe_on;
		(ctl0_r[13:12] == 2'h1)[*4] |-> io_oe[0];
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("enable on not driving");
	property p_oe_off;
		(ctl0_r[13:12] == 2'h0)[*4] |-> !io_oe[0];
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("enable off driving");
	property p_oe_glb;
		(ctl0_r[16:12] == 5'h02 && $stable(output_enable_pin_a_low))[*5]
			|-> io_oe[0] == !output_enable_pin_a_low;
	endproperty
	a_oe_glb: assert property (p_oe_glb) else $error("global enable wrong");
	property p_hold;
		(ctl0_r[2] && ctl0_r[6:3] == 4'h0 && ctl0_r[18:17] == 2'h0 && !global_clock_pin_a)[*6]
			|-> $stable(io_out[0]);
	endproperty
	a_hold: assert property (p_hold) else $error("register moved without clock");
	property p_gclr;
		(ctl0_r[2] && ctl0_r[6] && !global_clear_pin_low)[*6] |-> !io_out[0];
	endproperty
	a_gclr: assert property (p_gclr) else $error("global clear ignored");
	// main scenarios reached
	c_readback: cover property (reg_rd && reg_addr == 11'h014);
	c_gclr: cover property (ctl0_r[6] && !global_clear_pin_low);
	c_oe_glb: cover property (ctl0_r[13:12] == 2'h2 && !output_enable_pin_a_low);
endmodule
bind pma_top pma_top_sva u_pma_top_sva (
	.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.global_clock_pin_a(global_clock_pin_a), .global_clear_pin_low(global_clear_pin_low),
	.output_enable_pin_a_low(output_enable_pin_a_low), .io_out(io_out), .io_oe(io_oe)
);
`default_nettype wire

// ---- bench/pma_top_tb.sv ----
// self-checking bench for the macrocell array top
`timescale 1ns/10ps
`default_nettype none
module pma_top_tb;
	import pma_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [AW-1:0] reg_addr = 11'h000;
	logic [DW-1:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DW-1:0] reg_rdata;
	logic global_clock_pin_a = 1'b0;
	logic global_clear_pin_low = 1'b1;
	logic output_enable_pin_a_low = 1'b1;
	logic output_enable_pin_b_low = 1'b1;
	logic [N_IO-1:0] io_in = 32'h0;
	logic [N_IO-1:0] io_out;
	logic [N_IO-1:0] io_oe;
	int n_fail = 0;
	int check_count = 0;
	// device under test
	pma_top u_pma_top (
		.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.global_clock_pin_a(global_clock_pin_a), .global_clear_pin_low(global_clear_pin_low),
		.output_enable_pin_a_low(output_enable_pin_a_low),
		.output_enable_pin_b_low(output_enable_pin_b_low),
		.io_in(io_in), .io_out(io_out), .io_oe(io_oe)
	);
	// 250 MHz clock
	initial
	begin
		forever #2 sys_clk = ~sys_clk;
	end
	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// read strobe one cycle, data taken in the cycle after
	task automatic rchk(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(nm, reg_rdata, exp);
	endtask
	task automatic clk_pulse();
		@(posedge sys_clk);
		global_clock_pin_a <= 1'b1;
		repeat (4) @(posedge sys_clk);
		global_clock_pin_a <= 1'b0;
		tick(6);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		tick(1);
		chk("io_out", io_out, 32'h0);
		chk("io_oe", io_oe, 32'h0);
		rchk("ctl reset", 11'h014, 32'h0);
		rchk("unmapped", 11'h424, 32'h0);
		wr(11'h421, 32'hFFFF_FFFF);
		rchk("status ro", 11'h421, 32'h0);
		$display("test reset done");
		@(posedge sys_clk);
		io_in <= 32'hA5A5_0F0F;
		output_enable_pin_a_low <= 1'b0;
		tick(4);
		rchk("ded status", 11'h423, 32'h0000_000A);
		rchk("io status", 11'h422, 32'hA5A5_0F0F);
		$display("test status done");
		// line 0 of block 0 takes io_in[1], term 0 uses line 0
		wr(11'h400, 32'h0000_0085);
		wr(11'h000, 32'h0000_0001);
		for (int p = 0; p < 2; p++)
		begin
			wr(11'h014, 32'h0000_1000 | (p << 8));
			rchk("ctl back", 11'h014, 32'h0000_1000 | (p << 8));
			for (int v = 0; v < 2; v++)
			begin
				@(posedge sys_clk);
				io_in[1] <= v[0];
				tick(6);
				chk("comb out", io_out[0], v[0] ^ p[0]);
				chk("oe on", io_oe[0], 1'b1);
			end
		end
		$display("test comb done");
		// each flop type: clear, no edge, then two clock edges with input high
		for (int t = 0; t < 4; t++)
		begin
			wr(11'h014, 32'h0000_1044 | t);
			@(posedge sys_clk);
			global_clear_pin_low <= 1'b0;
			tick(6);
			chk("cleared", io_out[0], 1'b0);
			@(posedge sys_clk);
			global_clear_pin_low <= 1'b1;
			wr(11'h014, 32'h0000_1004 | t);
			tick(6);
			chk("no edge", io_out[0], 1'b0);
			clk_pulse();
			chk("edge 1", io_out[0], 1'b1);
			clk_pulse();
			chk("edge 2", io_out[0], t != 1);
		end
		$display("test flops done");
		wr(11'h014, 32'h0000_0000);
		tick(4);
		chk("oe off", io_oe[0], 1'b0);
		for (int i = 0; i < 2; i++)
		begin
			wr(11'h014, 32'h0000_2000 | (i << 14));
			for (int v = 0; v < 2; v++)
			begin
				@(posedge sys_clk);
				if (i == 0)
					output_enable_pin_a_low <= v[0];
				else
					output_enable_pin_b_low <= v[0];
				tick(6);
				chk("oe global", io_oe[0], !v[0]);
			end
		end
		$display("test oe done");
		// macrocell 1 borrows the set of macrocell 0, which gives it away
		wr(11'h014, 32'h0000_0800);
		wr(11'h034, 32'h0000_0200);
		for (int v = 0; v < 2; v++)
		begin
			@(posedge sys_clk);
			io_in[1] <= v[0];
			tick(6);
			chk("borrowed", io_out[1], v[0]);
			chk("lender", io_out[0], 1'b0);
		end
		$display("test expander done");
		report_and_stop();
	end
	// watchdog: the tests take well under a thousand cycles
	initial
	begin
		#100000;
		n_fail++;
		report_and_stop();
	end
endmodule
`default_nettype wire
